/* File: hw/serial_peripheral_port.sv */
// serial peripheral port: byte shift engine, master/slave, with an AXI4-Lite register slave
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module serial_peripheral_port
	import serial_port_pkg::*;
(
	input  wire logic        clk,              // 25 MHz system clock
	input  wire logic        rst_n,            // asynchronous reset, active low
	input  wire logic        halt,             // processor halted, shifting carries on
	input  wire logic [11:0] s_axi_awaddr,     // write address
	input  wire logic        s_axi_awvalid,    // write address valid
	output logic             s_axi_awready,    // write address ready
	input  wire logic [31:0] s_axi_wdata,      // write data
	input  wire logic [3:0]  s_axi_wstrb,      // write byte strobes
	input  wire logic        s_axi_wvalid,     // write data valid
	output logic             s_axi_wready,     // write data ready
	output logic [1:0]       s_axi_bresp,      // write response
	output logic             s_axi_bvalid,     // write response valid
	input  wire logic        s_axi_bready,     // write response ready
	input  wire logic [11:0] s_axi_araddr,     // read address
	input  wire logic        s_axi_arvalid,    // read address valid
	output logic             s_axi_arready,    // read address ready
	output logic [31:0]      s_axi_rdata,      // read data
	output logic [1:0]       s_axi_rresp,      // read response
	output logic             s_axi_rvalid,     // read data valid
	input  wire logic        s_axi_rready,     // read data ready
	input  wire logic        sck_in,           // serial clock pin level
	input  wire logic        sdi_in,           // data-in pin level
	input  wire logic        cs_n_in,          // slave_select_n pin level
	output pin_out_t         pin_out,          // levels driven on sck, sdo, slave_select_n
	output pin_oe_n_t        pin_oe_n,         // output enables, low drives the pin
	output logic             pins_function,    // shared_port_pins belong to the port
	output logic             pullup_disable,   // pull-ups on shared_port_pins off
	output logic             serial_bus_interrupt // transfer done, level
);

	logic [7:0]   ctrl_reg;
	logic [2:0]   option_reg;
	logic [7:0]   data_reg;
	logic [7:0]   shift_reg;
	logic [3:0]   bit_cnt_reg;
	logic [4:0]   half_cnt_reg;
	logic         prescale_reg;
	logic         sck_reg;
	logic         sdo_reg;
	logic         busy_reg;
	logic         enable_seen_reg;
	shift_state_t state_reg;
	logic [2:0]   sck_sync_reg;
	logic [2:0]   sdi_sync_reg;
	logic [2:0]   cs_sync_reg;
	logic         sck_level_reg;
	logic         aw_held_reg;
	logic         w_held_reg;
	logic [11:0]  aw_addr_reg;
	logic [31:0]  w_data_reg;
	logic [3:0]   w_strb_reg;

	// register map, low byte of each word, upper bits read zero:
	//   control: source select, role/rate pair, enable, bit order,
	//            select enable, collision flag, done flag
	//   data:    a write loads the shift buffer only, a read gives the
	//            byte latched at the end of the last completed transfer
	//   option:  clock polarity, collision detect, select line
	// unmapped offsets answer with a slave error and change nothing
	//
	// write path: address and data are each held once taken, in either
	// order; the register acts in the cycle after the later one, and the
	// response rises at the same clock edge as the register write
	// read path: data is registered, so rvalid follows arvalid by one cycle
	//
	// the flags live in the control register itself so that a software
	// write and a hardware event in the same cycle resolve in one place;
	// the event wins, otherwise a completion could be lost
	//
	// control field views
	wire       port_enable        = ctrl_reg[ctrl_port_enable_bit];
	wire [1:0] role_rate          = {ctrl_reg[ctrl_role_rate_high_bit], ctrl_reg[ctrl_role_rate_low_bit]};
	wire       slave_role         = (role_rate == rate_slave);
	wire       msb_first          = ctrl_reg[ctrl_bit_order_bit];
	wire       select_option      = option_reg[opt_select_line_bit];
	wire       select_line_enable = ctrl_reg[ctrl_select_enable_bit] & select_option;
	wire       clock_polarity     = option_reg[opt_clock_polarity_bit];
	wire       collision_option   = option_reg[opt_collision_detect_bit];

	// rate selection
	//   00: one base tick per half period, fastest master rate
	//   01: two base ticks per half period, base/4
	//   10: eight base ticks per half period, base/16
	//   11: slave, timing taken from the clock pin
	// the divider is free running; a start clears it so the first half
	// period of a byte is full length when the source bit is set; with it
	// clear the prescaler is not cleared, so it can be one system clock short
	//
	// base clock enable: every cycle when source bit set, every other cycle otherwise
	wire base_tick = ctrl_reg[ctrl_clock_source_bit] | prescale_reg;

	wire [4:0] half_period = (role_rate == rate_div4)  ? half_div4 :
	                         (role_rate == rate_div16) ? half_div16 : half_base;
	wire half_tick = base_tick && (half_cnt_reg == half_period - 5'h01);

	// slave side limitation: every pin passes three flops, so the
	// external clock must stay in each level for at least two system
	// clocks; faster masters lose bits
	//
	// pin synchronisers: a change counts once stages two and three agree
	wire sck_stable    = (sck_sync_reg[1] == sck_sync_reg[2]);
	wire sck_now       = sck_stable ? sck_sync_reg[2] : sck_level_reg;
	// polarity option 1 makes the inverted clock the timing reference
	wire ext_lead      = (sck_now != sck_level_reg) && (sck_now == ~clock_polarity);
	wire ext_trail     = (sck_now != sck_level_reg) && (sck_now == clock_polarity);
	wire sdi_bit       = sdi_sync_reg[2];
	wire cs_asserted   = ~cs_sync_reg[2] | ~select_line_enable;
	wire slave_go      = slave_role && cs_asserted;

	wire master_lead   = ~slave_role && half_tick && (state_reg == st_lead);
	wire master_trail  = ~slave_role && half_tick && (state_reg == st_trail);
	wire lead_edge     = slave_role ? (slave_go && ext_lead)  : master_lead;
	wire trail_edge    = slave_role ? (slave_go && ext_trail) : master_trail;
	wire last_bit      = (bit_cnt_reg == bits_per_byte - 4'h1);
	wire byte_done     = busy_reg && trail_edge && last_bit;
	wire [7:0] shifted = msb_first ? {shift_reg[6:0], sdi_bit} : {sdi_bit, shift_reg[7:1]};
	wire out_bit       = msb_first ? shift_reg[7] : shift_reg[0];

	// the shift buffer is one register for both directions: the leading
	// edge takes a bit in at one end while the trailing edge presents the
	// next bit from the other end
	//
	// register bus decode
	wire        wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire        wr_ctrl   = wr_fire && (aw_addr_reg == ctrl_addr) && w_strb_reg[0];
	wire        wr_data   = wr_fire && (aw_addr_reg == data_addr) && w_strb_reg[0];
	wire        wr_option = wr_fire && (aw_addr_reg == option_addr) && w_strb_reg[0];
	wire        wr_mapped = (aw_addr_reg == ctrl_addr) || (aw_addr_reg == data_addr) ||
	                        (aw_addr_reg == option_addr);
	wire        rd_mapped = (s_axi_araddr == ctrl_addr) || (s_axi_araddr == data_addr) ||
	                        (s_axi_araddr == option_addr);
	wire [7:0]  ctrl_view = {ctrl_reg[7:3], select_line_enable, ctrl_reg[1:0]};
	wire [31:0] rd_word   = (s_axi_araddr == ctrl_addr)   ? {24'h000000, ctrl_view} :
	                        (s_axi_araddr == data_addr)   ? {24'h000000, data_reg} :
	                        (s_axi_araddr == option_addr) ? {29'h00000000, option_reg} : 32'h00000000;
	wire        data_load = wr_data && port_enable && !busy_reg;
	wire        collision = wr_data && port_enable && busy_reg && collision_option;
	wire        start     = data_load && ~slave_role;
	wire [7:0]  wbyte     = w_data_reg[7:0];

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? resp_okay : resp_slverr;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read data is captured when the address is taken; a later change of
	// the addressed register does not alter an answer already waiting
	//
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_mapped ? resp_okay : resp_slverr;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// disabling the port clears both flags, even in the cycle of the
	// write that disables it, so no stale completion survives a restart
	//
	// control register; hardware set of a flag wins over a software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg   <= ctrl_reset;
			option_reg <= option_reset;
		end else begin
			if (wr_option)
				option_reg <= wbyte[2:0];
			if (wr_ctrl) begin
				ctrl_reg[7:2] <= wbyte[7:2];
				ctrl_reg[ctrl_collision_bit] <= wbyte[ctrl_collision_bit] | collision;
				ctrl_reg[ctrl_done_bit]      <= wbyte[ctrl_done_bit] | byte_done;
				if (!wbyte[ctrl_port_enable_bit])
					ctrl_reg[1:0] <= 2'h0;
			end else if (!port_enable) begin
				ctrl_reg[1:0] <= 2'h0;
			end else begin
				if (collision)
					ctrl_reg[ctrl_collision_bit] <= 1'b1;
				if (byte_done)
					ctrl_reg[ctrl_done_bit] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_sync_reg  <= 3'h0;
			sdi_sync_reg  <= 3'h0;
			cs_sync_reg   <= 3'h7;
			sck_level_reg <= 1'b0;
			prescale_reg  <= 1'b0;
		end else begin
			sck_sync_reg  <= {sck_sync_reg[1:0], sck_in};
			sdi_sync_reg  <= {sdi_sync_reg[1:0], sdi_in};
			cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_in};
			sck_level_reg <= sck_now;
			prescale_reg  <= ~prescale_reg;
		end
	end

	// the halt input is kept only to show the port as halt tolerant;
	// nothing below looks at it, and reception goes on
	//
	// shift engine; halt is deliberately not an input to it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg       <= st_idle;
			busy_reg        <= 1'b0;
			bit_cnt_reg     <= 4'h0;
			half_cnt_reg    <= 5'h00;
			shift_reg       <= data_reset;
			data_reg        <= data_reset;
			sck_reg         <= 1'b0;
			sdo_reg         <= 1'b0;
			enable_seen_reg <= 1'b0;
		end else if (!port_enable) begin
			state_reg       <= st_idle;
			busy_reg        <= 1'b0;
			enable_seen_reg <= 1'b0;
			sck_reg         <= 1'b0;
			sdo_reg         <= 1'b0;
		end else begin
			enable_seen_reg <= 1'b1;
			if (!enable_seen_reg) begin
				sck_reg <= 1'b0;
				sdo_reg <= 1'b0;
			end
			if (base_tick)
				half_cnt_reg <= half_tick ? 5'h00 : half_cnt_reg + 5'h01;
			if (data_load) begin
				shift_reg    <= wbyte;
				sdo_reg      <= msb_first ? wbyte[7] : wbyte[0];
				bit_cnt_reg  <= 4'h0;
				half_cnt_reg <= 5'h00;
				busy_reg     <= start;
				state_reg    <= start ? st_lead : st_idle;
				sck_reg      <= 1'b0;
			end else begin
				case (state_reg)
					st_idle: begin
						if (slave_role && slave_go && ext_lead)
							busy_reg <= 1'b1;
					end
					st_lead: begin
						if (master_lead) begin
							sck_reg   <= 1'b1;
							state_reg <= st_trail;
						end
					end
					st_trail: begin
						if (master_trail) begin
							sck_reg   <= 1'b0;
							state_reg <= last_bit ? st_idle : st_lead;
						end
					end
					default: state_reg <= st_idle;
				endcase
				if (lead_edge && (busy_reg || slave_role))
					shift_reg <= shifted;
				if (trail_edge && (busy_reg || (slave_role && slave_go))) begin
					sdo_reg <= msb_first ? shift_reg[7] : shift_reg[0];
					bit_cnt_reg <= last_bit ? 4'h0 : bit_cnt_reg + 4'h1;
				end
				if (byte_done) begin
					busy_reg <= 1'b0;
					data_reg <= shift_reg;
				end
			end
		end
	end

	// pins: output enables active low; all float while disabled
	wire master_drive = port_enable & ~slave_role;
	wire select_drive = master_drive & select_line_enable;
	wire cs_level     = ~busy_reg & enable_seen_reg;

	always_comb begin
		pin_out.sck   = sck_reg ^ clock_polarity;
		pin_out.sdo   = sdo_reg;
		pin_out.cs_n  = cs_level;
		pin_oe_n.sck  = ~master_drive;
		pin_oe_n.sdo  = ~port_enable;
		pin_oe_n.sdi  = 1'b1;
		pin_oe_n.cs_n = ~select_drive;
	end

	// pin ownership and pull-up control simply follow the enable bit;
	// an external pull-up on the select pin keeps it high while floating
	//

	assign pins_function        = port_enable;
	assign pullup_disable       = port_enable;
	assign serial_bus_interrupt = ctrl_reg[ctrl_done_bit];

	wire unused_ok = &{1'b0, halt, out_bit, s_axi_wdata[31:8], w_data_reg[31:8], w_strb_reg[3:1]};

endmodule : serial_peripheral_port

/* File: hw/serial_port_pkg.sv */
// package: register map, field positions, reset values and types for the serial port
package serial_port_pkg;

	localparam logic [11:0] ctrl_addr      = 12'h000;
	localparam logic [11:0] data_addr      = 12'h004;
	localparam logic [11:0] option_addr    = 12'h008;

	localparam int ctrl_clock_source_bit    = 7;
	localparam int ctrl_role_rate_high_bit  = 6;
	localparam int ctrl_role_rate_low_bit   = 5;
	localparam int ctrl_port_enable_bit     = 4;
	localparam int ctrl_bit_order_bit       = 3;
	localparam int ctrl_select_enable_bit   = 2;
	localparam int ctrl_collision_bit       = 1;
	localparam int ctrl_done_bit            = 0;

	localparam int opt_clock_polarity_bit   = 0;
	localparam int opt_collision_detect_bit = 1;
	localparam int opt_select_line_bit      = 2;

	localparam logic [7:0] ctrl_reset       = 8'h60;
	localparam logic [2:0] option_reset     = 3'h0;
	localparam logic [7:0] data_reset       = 8'h00;

	localparam logic [1:0] rate_base        = 2'h0;
	localparam logic [1:0] rate_div4        = 2'h1;
	localparam logic [1:0] rate_div16       = 2'h2;
	localparam logic [1:0] rate_slave       = 2'h3;

	localparam logic [4:0] half_base        = 5'h01;
	localparam logic [4:0] half_div4        = 5'h02;
	localparam logic [4:0] half_div16       = 5'h08;
	localparam logic [3:0] bits_per_byte    = 4'h8;

	localparam logic [1:0] resp_okay        = 2'h0;
	localparam logic [1:0] resp_slverr      = 2'h2;

	typedef enum {st_idle, st_lead, st_trail} shift_state_t;

	typedef struct packed {
		logic sck;
		logic sdo;
		logic cs_n;
	} pin_out_t;

	typedef struct packed {
		logic sck;
		logic sdo;
		logic sdi;
		logic cs_n;
	} pin_oe_n_t;

endpackage : serial_port_pkg

/* File: sim/serial_port_monitor.sv */
// checker: bus answers and pin ownership of the serial port
`timescale 1ns/1ns
module serial_port_monitor
	import serial_port_pkg::*;
(
	input wire logic      clk,                  // system clock
	input wire logic      rst_n,                // async reset, active low
	input wire logic      s_axi_awvalid,        // aw valid
	input wire logic      s_axi_awready,        // aw ready
	input wire logic      s_axi_wvalid,         // w valid
	input wire logic      s_axi_wready,         // w ready
	input wire logic      s_axi_bvalid,         // b valid
	input wire logic      s_axi_bready,         // b ready
	input wire logic      s_axi_arvalid,        // ar valid
	input wire logic      s_axi_arready,        // ar ready
	input wire logic      s_axi_rvalid,         // r valid
	input wire logic      s_axi_rready,         // r ready
	input wire pin_out_t  pin_out,              // driven pin levels
	input wire pin_oe_n_t pin_oe_n,             // pin enables, low drives
	input wire logic      pins_function,        // pins owned by the port
	input wire logic      pullup_disable,       // pull-ups off
	input wire logic      serial_bus_interrupt  // transfer done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	float_off_a: assert property (!pins_function |-> pin_oe_n == 4'hf)
		else $error("pins driven while port disabled");
	sdi_input_a: assert property (pin_oe_n.sdi)
		else $error("data-in pin driven");
	pullup_off_a: assert property (pullup_disable == pins_function)
		else $error("pull-up control differs from pin ownership");
	sck_owner_a: assert property (!pin_oe_n.sck |-> pins_function)
		else $error("clock driven while port disabled");
	irq_rise_a: assert property ($rose(serial_bus_interrupt) |-> pins_function)
		else $error("done flag rose while disabled");
	irq_clear_a: assert property (!pins_function |=> !serial_bus_interrupt)
		else $error("done flag kept while disabled");
	cs_frame_a: assert property ($changed(pin_out.sck) && !pin_oe_n.sck && !pin_oe_n.cs_n |-> $past(!pin_out.cs_n))
		else $error("clock moved with select high");
	wr_answer_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read data late");
	wr_retire_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	rd_retire_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
endmodule : serial_port_monitor

bind serial_peripheral_port serial_port_monitor mon (.clk(clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pins_function(pins_function),
	.pullup_disable(pullup_disable), .serial_bus_interrupt(serial_bus_interrupt));

/* File: sim/spi_slave_model.sv */
// far-side model: external slave, msb first, samples on rising clock
`timescale 1ns/1ns
module spi_slave_model (
	input  wire logic       sck,      // serial clock wire
	input  wire logic       sdo,      // data from the port
	input  wire logic       load,     // rising edge loads tx_byte
	input  wire logic [7:0] tx_byte,  // byte to send back
	output logic            sdi,      // data to the port
	output logic [7:0]      rx_byte,  // byte captured
	output int              bits      // bits captured since load
);
	logic [7:0] sh;
	initial begin
		sdi = 1'b0;
		rx_byte = 8'h00;
		bits = 0;
		sh = 8'h00;
	end
	always @(posedge load) begin
		sh = tx_byte;
		sdi = tx_byte[7];
		bits = 0;
	end
	always @(posedge sck) begin
		rx_byte = {rx_byte[6:0], sdo};
		bits = bits + 1;
	end
	// released line shows the inverse so stale data cannot pass
	always @(negedge sck) begin
		sh = {sh[6:0], ~sh[7]};
		sdi = (bits < 8) ? sh[7] : ~sdi;
	end
endmodule : spi_slave_model

/* File: sim/tb.sv */
// testbench: register-level tests of the serial port against a slave model
`timescale 1ns/1ns
module tb import serial_port_pkg::*; ;
	logic        clk = 1'b0, rst_n = 1'b0, halt = 1'b0, load = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        irq, pins_function, pullup_disable, sck_w, sdo_w, cs_w, sdi_w;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [7:0]  ptx = 8'h00, prx;
	pin_out_t    pin_out;
	pin_oe_n_t   pin_oe_n;
	int          pbits, rises = 0, per_seen = 0, fails = 0, checks = 0;
	time         t0 = 0;
	always #20 clk = ~clk;
	assign sck_w = pin_oe_n.sck ? 1'b0 : pin_out.sck;
	assign sdo_w = pin_oe_n.sdo ? 1'b1 : pin_out.sdo;
	assign cs_w = pin_oe_n.cs_n ? 1'b1 : pin_out.cs_n;
	serial_peripheral_port dut (.clk(clk), .rst_n(rst_n), .halt(halt), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck_in(sck_w),
		.sdi_in(sdi_w), .cs_n_in(cs_w), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pins_function(pins_function),
		.pullup_disable(pullup_disable), .serial_bus_interrupt(irq));
	spi_slave_model peer (.sck(sck_w), .sdo(sdo_w), .load(load), .tx_byte(ptx), .sdi(sdi_w), .rx_byte(prx),
		.bits(pbits));
	always @(posedge sck_w) begin
		if (rises == 1) per_seen = int'(($time - t0) / 40);
		t0 = $time;
		rises = rises + 1;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks = checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : rd
	// one master transfer with a collision attempt while it runs
	task automatic xfer(input logic [2:0] opt, input logic [7:0] ctl, tx, tp, rp, re, input int per,
		input bit dchk, input bit clr);
		logic [7:0] ce;
		int n;
		ce = {ctl[7:3], ctl[2] & opt[2], 2'b00};
		wr(option_addr, {29'h0, opt});
		wr(ctrl_addr, {24'h0, ctl});
		chk("select pin enable", {31'h0, ~ce[2]}, {31'h0, pin_oe_n.cs_n});
		ptx <= tp;
		load <= 1'b1;
		rises = 0;
		wr(data_addr, {24'h0, tx});
		load <= 1'b0;
		wr(data_addr, 32'h0000_0011);
		rd(ctrl_addr);
		chk("collision flag", {24'h0, ce | {6'h0, opt[1], 1'b0}}, rdat);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n = n + 1;
		end
		chk("clock rises", 32'd8, rises);
		chk("clock period", 32'(per), 32'(per_seen));
		rd(ctrl_addr);
		chk("done flag", {24'h0, ce | {6'h0, opt[1], 1'b1}}, rdat);
		if (dchk) begin
			chk("sent byte", {24'h0, rp}, {24'h0, prx});
			rd(data_addr);
			chk("received byte", {24'h0, re}, rdat);
		end
		if (clr) begin
			wr(ctrl_addr, {24'h0, ctl});
			chk("interrupt cleared", 32'h0, {31'h0, irq});
		end
	endtask : xfer
	task automatic summarize();
		if (fails == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge clk);
		fails = fails + 1;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		halt <= 1'b1;
		rd(ctrl_addr);
		chk("control reset", {24'h0, ctrl_reset}, rdat);
		rd(data_addr);
		chk("data reset", {24'h0, data_reset}, rdat);
		rd(option_addr);
		chk("option reset", {29'h0, option_reset}, rdat);
		rd(12'hffc);
		chk("unmapped read", {30'h0, resp_slverr}, {30'h0, resp});
		wr(12'hffc, 32'hff);
		chk("unmapped write", {30'h0, resp_slverr}, {30'h0, resp});
		chk("float while off", 32'hf, {28'h0, pin_oe_n});
		wr(option_addr, 32'h6);
		wr(ctrl_addr, 32'hdc);
		chk("lines low on enable", 32'h0, {29'h0, pin_out});
		chk("pins owned", 32'h3, {30'h0, pins_function, pullup_disable});
		xfer(3'h6, 8'hdc, 8'ha5, 8'h3c, 8'ha5, 8'h3c, 16, 1'b1, 1'b1);
		xfer(3'h4, 8'h54, 8'h01, 8'h12, 8'h80, 8'h48, 32, 1'b1, 1'b1);
		xfer(3'h0, 8'h34, 8'h5a, 8'h00, 8'h00, 8'h00, 8, 1'b0, 1'b1);
		xfer(3'h2, 8'h9c, 8'h5a, 8'h00, 8'h00, 8'h00, 2, 1'b0, 1'b0);
		wr(option_addr, 32'h1);
		chk("idle clock level", 32'h1, {31'h0, pin_out.sck});
		wr(ctrl_addr, 32'h8f);
		rd(ctrl_addr);
		chk("flags on disable", 32'h88, rdat);
		chk("float after off", 32'hf, {28'h0, pin_oe_n});
		chk("pins released", 32'h0, {30'h0, pins_function, pullup_disable});
		summarize();
	end
endmodule : tb
